/* rsq_pkg.sv */
// Constants for the serial flash reset sequencer: timing, counts, states.
// Assumes a single 40 MHz clock; all times are converted to cycles here.
package rsq_pkg;
   localparam int CLK_MHZ = 40;
   localparam int POWER_UP_INTERVAL_US = 300;
   localparam int RESET_PULSE_WIDTH_NS = 200;
   localparam int RESET_PULSE_HOLD_US = 35;
   localparam int SELECT_HIGH_TIME_NS = 20;
   localparam int OUTPUT_DISABLE_TIME_NS = 20;
   // Least times round up, longest times round down, never below one cycle
   localparam int POWER_UP_CYCLES = POWER_UP_INTERVAL_US * CLK_MHZ;
   localparam int RESET_PULSE_WIDTH_CYCLES = (RESET_PULSE_WIDTH_NS * CLK_MHZ + 999) / 1000;
   localparam int RESET_PULSE_HOLD_CYCLES = RESET_PULSE_HOLD_US * CLK_MHZ;
   localparam int SELECT_HIGH_CYCLES_RAW = (SELECT_HIGH_TIME_NS * CLK_MHZ + 999) / 1000;
   localparam int SELECT_HIGH_CYCLES = (SELECT_HIGH_CYCLES_RAW < 1) ? 1 : SELECT_HIGH_CYCLES_RAW;
   localparam int OUTPUT_DISABLE_CYCLES_RAW = (OUTPUT_DISABLE_TIME_NS * CLK_MHZ) / 1000;
   localparam int OUTPUT_DISABLE_CYCLES =
      (OUTPUT_DISABLE_CYCLES_RAW < 1) ? 1 : OUTPUT_DISABLE_CYCLES_RAW;
   // Warm reset hold counted after qualification, so low-to-ready stays at the hold time
   localparam int WARM_HOLD_CYCLES = RESET_PULSE_HOLD_CYCLES - RESET_PULSE_WIDTH_CYCLES;
   localparam int SOFT_RESET_CYCLES = RESET_PULSE_HOLD_CYCLES;
   localparam int SEQ_CNT_W = 14;

   typedef enum logic [4:0] {
      RSQ_POR   = 5'h01,
      RSQ_HOLD  = 5'h02,
      RSQ_READY = 5'h04,
      RSQ_WARM  = 5'h08,
      RSQ_SOFT  = 5'h10
   } rsq_state_e;
endpackage : rsq_pkg

/* rsq_qual_if.sv */
// Carrier between the sequencer and one reset pulse qualifier.
// Assumes both ends share clk_i.
`timescale 1ns/100ps
`default_nettype none
interface rsq_qual_if;
   logic arm;
   logic low;
   logic fire;
   modport src (output arm, output low, input fire);
   modport qual (input arm, input low, output fire);
endinterface : rsq_qual_if
`default_nettype wire

/* rsq_pulse_qual.sv */
// Reset low pulse qualifier: a high-to-low edge followed by WIDTH low cycles.
// Assumes the level is already synchronous to clk_i.
`timescale 1ns/100ps
`default_nettype none
module rsq_pulse_qual #(
   parameter int WIDTH = rsq_pkg::RESET_PULSE_WIDTH_CYCLES
) (
   input wire logic clk_i,
   input wire logic reset_i,
   rsq_qual_if.qual q
);
   localparam int CW = $clog2(WIDTH + 1);
   logic [CW-1:0] cnt;
   logic [CW-1:0] next_cnt;
   logic seen_high;
   logic next_seen_high;
   logic fire;
   logic next_fire;

   always_comb begin
      next_cnt = cnt;
      next_seen_high = seen_high;
      next_fire = 1'b0;
      if (!q.arm) begin
         next_cnt = '0;
         next_seen_high = 1'b0;
      end else if (!q.low) begin
         // Only a transition from high counts as a reset
         next_seen_high = 1'b1;
         next_cnt = '0;
      end else if (seen_high) begin
         if (cnt == CW'(WIDTH - 1)) begin
            next_fire = 1'b1;
            next_seen_high = 1'b0;
            next_cnt = '0;
         end else begin
            next_cnt = cnt + 1'b1;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         cnt <= '0;
         seen_high <= 1'b0;
         fire <= 1'b0;
      end else begin
         cnt <= next_cnt;
         seen_high <= next_seen_high;
         fire <= next_fire;
      end
   end

   assign q.fire = fire;

   short_pulse_a: assert property (@(posedge clk_i) disable iff (reset_i)
      fire |-> $past(q.low, 1) && $past(q.low, 8) && $past(q.arm, 8))
      else $error("reset fired without a full-width low pulse");
endmodule : rsq_pulse_qual
`default_nettype wire

/* rsq_sequencer.sv */
// Reset sequencer of a serial multi-I/O flash: power-on, warm pin and software reset.
// Assumes reset_i marks supply rising above its minimum; pins are synchronous.
`timescale 1ns/100ps
`default_nettype none
module rsq_sequencer #(
   parameter int POR_CYCLES = rsq_pkg::POWER_UP_CYCLES
) (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic rst_pin_n_i,
   input wire logic shared_line3_reset_pin_i,
   input wire logic cs_n_i,
   input wire logic quad_enable_bit_i,
   input wire logic pin_reset_enable_bit_i,
   input wire logic soft_reset_cmd_i,
   input wire logic por_fault_i,
   input wire logic quad_read_end_i,
   output logic ready_o,
   output logic outputs_float_o,
   output logic abort_o,
   output logic por_busy_o,
   output logic data_line_3_o,
   output logic data_line_3_oe_o
);
   localparam int CW = rsq_pkg::SEQ_CNT_W;
   localparam int DW = $clog2(rsq_pkg::OUTPUT_DISABLE_CYCLES + 1);
   localparam int SW = $clog2(rsq_pkg::SELECT_HIGH_CYCLES + 1);

   rsq_pkg::rsq_state_e state;
   rsq_pkg::rsq_state_e next_state;
   logic [CW-1:0] cnt;
   logic [CW-1:0] next_cnt;
   logic por_ok;
   logic next_por_ok;
   logic [SW-1:0] cs_high_cnt;
   logic [SW-1:0] next_cs_high_cnt;
   logic [DW-1:0] drv_cnt;
   logic [DW-1:0] next_drv_cnt;
   logic next_ready;
   logic next_float;
   logic next_abort;
   logic next_por_busy;
   logic next_line3_oe;
   logic shared_is_reset;
   logic pins_low;
   logic fire_any;

   rsq_qual_if ded_if ();
   rsq_qual_if shr_if ();

   // Shared pin is a reset input only outside quad, or when enabled after select high
   always_comb begin
      shared_is_reset = !quad_enable_bit_i ||
         (pin_reset_enable_bit_i && cs_n_i &&
          cs_high_cnt >= SW'(rsq_pkg::SELECT_HIGH_CYCLES));
   end

   assign ded_if.arm = (state == rsq_pkg::RSQ_READY);
   assign ded_if.low = !rst_pin_n_i;
   assign shr_if.arm = (state == rsq_pkg::RSQ_READY) && shared_is_reset;
   assign shr_if.low = !shared_line3_reset_pin_i;
   assign fire_any = ded_if.fire || shr_if.fire;
   assign pins_low = !rst_pin_n_i || (!quad_enable_bit_i && !shared_line3_reset_pin_i);

   rsq_pulse_qual #(.WIDTH(rsq_pkg::RESET_PULSE_WIDTH_CYCLES)) u_ded_qual (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .q(ded_if.qual)
   );

   rsq_pulse_qual #(.WIDTH(rsq_pkg::RESET_PULSE_WIDTH_CYCLES)) u_shr_qual (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .q(shr_if.qual)
   );

   always_comb begin
      next_state = state;
      next_cnt = cnt;
      next_por_ok = por_ok;
      case (state)
         rsq_pkg::RSQ_POR: begin
            if (cnt == CW'(POR_CYCLES - 1)) begin
               next_cnt = '0;
               next_por_ok = !por_fault_i;
               // Reset still low at the end keeps the device in reset
               next_state = pins_low ? rsq_pkg::RSQ_HOLD : rsq_pkg::RSQ_READY;
            end else begin
               next_cnt = cnt + 1'b1;
            end
         end
         rsq_pkg::RSQ_HOLD: begin
            if (!pins_low) begin
               next_state = rsq_pkg::RSQ_READY;
            end
         end
         rsq_pkg::RSQ_READY: begin
            next_cnt = '0;
            if (fire_any) begin
               next_state = por_ok ? rsq_pkg::RSQ_WARM : rsq_pkg::RSQ_POR;
            end else if (soft_reset_cmd_i && !pins_low) begin
               next_state = por_ok ? rsq_pkg::RSQ_SOFT : rsq_pkg::RSQ_POR;
            end
         end
         rsq_pkg::RSQ_WARM: begin
            if (cnt == CW'(rsq_pkg::WARM_HOLD_CYCLES - 1)) begin
               next_cnt = '0;
               next_state = rsq_pkg::RSQ_READY;
            end else begin
               next_cnt = cnt + 1'b1;
            end
         end
         rsq_pkg::RSQ_SOFT: begin
            if (cnt == CW'(rsq_pkg::SOFT_RESET_CYCLES - 1)) begin
               next_cnt = '0;
               next_state = rsq_pkg::RSQ_READY;
            end else begin
               next_cnt = cnt + 1'b1;
            end
         end
         default: begin
            next_state = rsq_pkg::RSQ_POR;
            next_cnt = '0;
         end
      endcase
   end

   always_comb begin
      next_ready = (next_state == rsq_pkg::RSQ_READY);
      next_float = (next_state != rsq_pkg::RSQ_READY);
      next_abort = (state == rsq_pkg::RSQ_READY) && (next_state != rsq_pkg::RSQ_READY);
      next_por_busy = (next_state == rsq_pkg::RSQ_POR);
      if (!cs_n_i) begin
         next_cs_high_cnt = '0;
      end else if (cs_high_cnt < SW'(rsq_pkg::SELECT_HIGH_CYCLES)) begin
         next_cs_high_cnt = cs_high_cnt + 1'b1;
      end else begin
         next_cs_high_cnt = cs_high_cnt;
      end
      // Line 3 driven high for the disable time, then released to the pull-up
      if (next_state != rsq_pkg::RSQ_READY) begin
         next_drv_cnt = '0;
      end else if (quad_read_end_i) begin
         next_drv_cnt = DW'(rsq_pkg::OUTPUT_DISABLE_CYCLES);
      end else if (drv_cnt != '0) begin
         next_drv_cnt = drv_cnt - 1'b1;
      end else begin
         next_drv_cnt = drv_cnt;
      end
      next_line3_oe = (next_drv_cnt != '0);
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         state <= rsq_pkg::RSQ_POR;
         cnt <= '0;
         por_ok <= 1'b0;
         cs_high_cnt <= '0;
         drv_cnt <= '0;
         ready_o <= 1'b0;
         outputs_float_o <= 1'b1;
         abort_o <= 1'b0;
         por_busy_o <= 1'b1;
         data_line_3_o <= 1'b0;
         data_line_3_oe_o <= 1'b0;
      end else begin
         state <= next_state;
         cnt <= next_cnt;
         por_ok <= next_por_ok;
         cs_high_cnt <= next_cs_high_cnt;
         drv_cnt <= next_drv_cnt;
         ready_o <= next_ready;
         outputs_float_o <= next_float;
         abort_o <= next_abort;
         por_busy_o <= next_por_busy;
         data_line_3_o <= next_line3_oe;
         data_line_3_oe_o <= next_line3_oe;
      end
   end

   por_not_ready_a: assert property (@(posedge clk_i) disable iff (reset_i)
      por_busy_o |-> !ready_o && outputs_float_o)
      else $error("device ready during power-on reset");

   por_length_a: assert property (@(posedge clk_i) disable iff (reset_i)
      (state == rsq_pkg::RSQ_POR) |-> (cnt < CW'(POR_CYCLES)))
      else $error("power-up interval overran");

   shared_gate_a: assert property (@(posedge clk_i) disable iff (reset_i)
      shr_if.arm |-> !quad_enable_bit_i || (pin_reset_enable_bit_i && cs_n_i))
      else $error("shared pin armed as reset when not allowed");

   por_ignore_a: assert property (@(posedge clk_i) disable iff (reset_i)
      (state == rsq_pkg::RSQ_POR) |-> !ded_if.arm && !shr_if.arm)
      else $error("reset pins armed during power-on reset");

   late_reset_a: assert property (@(posedge clk_i) disable iff (reset_i)
      (state == rsq_pkg::RSQ_POR && cnt == CW'(POR_CYCLES - 1) && !rst_pin_n_i)
      |=> !ready_o && outputs_float_o && state == rsq_pkg::RSQ_HOLD)
      else $error("device left reset while reset pin held low");

   warm_float_a: assert property (@(posedge clk_i) disable iff (reset_i)
      (fire_any && state == rsq_pkg::RSQ_READY && por_ok)
      |=> (outputs_float_o && abort_o && !data_line_3_oe_o) ##1 (!abort_o && !ready_o)[*8])
      else $error("warm reset did not float and abort");

   por_restart_a: assert property (@(posedge clk_i) disable iff (reset_i)
      (fire_any && state == rsq_pkg::RSQ_READY && !por_ok) |=> por_busy_o)
      else $error("pin reset after failed power-on did not restart it");

   soft_reset_a: assert property (@(posedge clk_i) disable iff (reset_i)
      (state == rsq_pkg::RSQ_READY && !fire_any && soft_reset_cmd_i && !pins_low && por_ok)
      |=> !ready_o && state == rsq_pkg::RSQ_SOFT)
      else $error("software reset not taken with pin high");

   select_low_a: assert property (@(posedge clk_i) disable iff (reset_i)
      (quad_enable_bit_i && !cs_n_i) |-> !shr_if.arm)
      else $error("shared pin treated as reset while selected");

   cs_rise_a: assert property (@(posedge clk_i) disable iff (reset_i)
      (quad_enable_bit_i && $rose(cs_n_i)) |-> !shr_if.arm)
      else $error("shared pin armed right after select rose");

   line3_high_a: assert property (@(posedge clk_i) disable iff (reset_i)
      (quad_read_end_i && next_state == rsq_pkg::RSQ_READY)
      |=> data_line_3_oe_o && data_line_3_o)
      else $error("line 3 not driven high after quad read");

   warm_cov: cover property (@(posedge clk_i) disable iff (reset_i)
      state == rsq_pkg::RSQ_WARM ##1 state == rsq_pkg::RSQ_READY);
   hold_cov: cover property (@(posedge clk_i) disable iff (reset_i)
      state == rsq_pkg::RSQ_HOLD ##1 state == rsq_pkg::RSQ_READY);
   soft_cov: cover property (@(posedge clk_i) disable iff (reset_i)
      state == rsq_pkg::RSQ_SOFT);
   line3_cov: cover property (@(posedge clk_i) disable iff (reset_i)
      $fell(data_line_3_oe_o));
endmodule : rsq_sequencer
`default_nettype wire

/* rsq_host_model.sv */
// Host-side model: drives chip select, the dedicated reset pin and line 3.
// Assumes the bench calls its tasks from one process at a time.
`timescale 1ns/100ps
`default_nettype none
module rsq_host_model (
   input wire logic clk_i,
   output logic cs_n_o,
   output logic rst_pin_n_o,
   output logic line3_o
);
   // Select starts high with the supply and stays so through power-up
   initial begin
      cs_n_o = 1'b1;
      rst_pin_n_o = 1'b1;
      line3_o = 1'b1;
   end

   task automatic drive(input logic cs, input logic rst, input logic l3);
      @(posedge clk_i);
      cs_n_o <= cs;
      rst_pin_n_o <= rst;
      line3_o <= l3;
   endtask : drive

   // Low pulse of n cycles; pins end high since a pull-up holds a released line
   task automatic pulse(input bit shared, input int n, input logic cs);
      repeat (3) @(posedge clk_i);
      cs_n_o <= cs;
      if (shared) begin
         line3_o <= 1'b0;
      end else begin
         rst_pin_n_o <= 1'b0;
      end
      repeat (n) @(posedge clk_i);
      cs_n_o <= 1'b1;
      rst_pin_n_o <= 1'b1;
      line3_o <= 1'b1;
   endtask : pulse
endmodule : rsq_host_model
`default_nettype wire

/* rsq_sequencer_tb.sv */
// Self-checking bench of the reset sequencer with a host model on its pins.
// Assumes a shortened power-on count; warm and soft lengths as in the package.
`timescale 1ns/100ps
`default_nettype none
module rsq_sequencer_tb;
   localparam int POR = 40;
   logic clk_i;
   logic reset_i;
   logic quad_en;
   logic pin_en;
   logic soft_cmd;
   logic por_fault;
   logic qre;
   wire cs_n;
   wire rst_n;
   wire line3;
   logic ready_o;
   logic float_o;
   logic abort_o;
   logic busy_o;
   logic l3_o;
   logic l3_oe;
   int n_fail = 0;
   int checks = 0;
   int n;

   initial begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end

   rsq_host_model host (.clk_i(clk_i), .cs_n_o(cs_n), .rst_pin_n_o(rst_n), .line3_o(line3));

   rsq_sequencer #(.POR_CYCLES(POR)) uut (
      .clk_i(clk_i), .reset_i(reset_i), .rst_pin_n_i(rst_n),
      .shared_line3_reset_pin_i(line3), .cs_n_i(cs_n), .quad_enable_bit_i(quad_en),
      .pin_reset_enable_bit_i(pin_en), .soft_reset_cmd_i(soft_cmd), .por_fault_i(por_fault),
      .quad_read_end_i(qre), .ready_o(ready_o), .outputs_float_o(float_o),
      .abort_o(abort_o), .por_busy_o(busy_o), .data_line_3_o(l3_o),
      .data_line_3_oe_o(l3_oe));

   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      checks++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR %s expected %0h seen %0h", what, exp, got);
      end
   endtask : chk

   task automatic low_len(output int k);
      k = 0;
      while (ready_o !== 1'b1 && k < 3000) begin
         @(posedge clk_i);
         #1;
         k++;
      end
   endtask : low_len

   // Cycles spent not ready after a reset starts; 0 if none started
   task automatic measure(output int k);
      int w;
      k = 0;
      for (w = 0; w < 40 && ready_o === 1'b1; w++) begin
         @(posedge clk_i);
         #1;
      end
      if (ready_o === 1'b0) begin
         chk("abort", 1'b1, abort_o);
         chk("float", 1'b1, float_o);
         low_len(k);
         chk("float_end", 1'b0, float_o);
      end
   endtask : measure

   task automatic do_reset(input logic fault);
      int k;
      @(posedge clk_i);
      reset_i <= 1'b1;
      por_fault <= fault;
      repeat (8) @(posedge clk_i);
      reset_i <= 1'b0;
      #1;
      chk("por_busy", 1'b1, busy_o);
      low_len(k);
      chk("por_len", 1'b1, k >= POR && k <= POR + 3);
      @(posedge clk_i);
      por_fault <= 1'b0;
   endtask : do_reset

   task automatic t_pin(input bit sh, input int w, input logic cs, input bit fires);
      fork
         host.pulse(sh, w, cs);
         measure(n);
      join
      if (fires) begin
         chk("warm_len", 1'b1, n >= 1390 && n <= 1396);
      end else begin
         chk("no_reset", 16'h0000, 16'(n));
      end
   endtask : t_pin

   task automatic t_soft();
      fork
         begin
            @(posedge clk_i);
            soft_cmd <= 1'b1;
            @(posedge clk_i);
            soft_cmd <= 1'b0;
         end
         measure(n);
      join
      chk("soft_len", 1'b1, n >= 1398 && n <= 1402);
   endtask : t_soft

   task automatic t_qend();
      @(posedge clk_i);
      qre <= 1'b1;
      @(posedge clk_i);
      qre <= 1'b0;
      #1;
      chk("l3_drive", 16'h0003, {14'h0, l3_oe, l3_o});
      @(posedge clk_i);
      #1;
      chk("l3_release", 1'b0, l3_oe);
   endtask : t_qend

   task automatic t_fault();
      do_reset(1'b1);
      fork
         host.pulse(0, 10, 1'b1);
         measure(n);
      join
      chk("full_por", 1'b1, n >= POR - 2 && n <= POR + 4);
   endtask : t_fault

   task automatic t_hold();
      host.drive(1'b1, 1'b0, 1'b1);
      reset_i <= 1'b1;
      repeat (8) @(posedge clk_i);
      reset_i <= 1'b0;
      repeat (POR + 20) @(posedge clk_i);
      #1;
      chk("hold_ready", 1'b0, ready_o);
      host.drive(1'b1, 1'b1, 1'b1);
      repeat (4) @(posedge clk_i);
      #1;
      chk("hold_end", 1'b1, ready_o);
   endtask : t_hold

   task automatic results();
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : results

   initial begin
      reset_i = 1'b1;
      quad_en = 1'b0;
      pin_en = 1'b0;
      soft_cmd = 1'b0;
      por_fault = 1'b0;
      qre = 1'b0;
      fork
         do_reset(1'b0);
         host.pulse(0, 10, 1'b1);
      join
      t_pin(0, 7, 1'b1, 0);
      t_pin(0, 10, 1'b1, 1);
      t_pin(1, 10, 1'b0, 1);
      @(posedge clk_i);
      quad_en <= 1'b1;
      t_pin(1, 10, 1'b1, 0);
      @(posedge clk_i);
      pin_en <= 1'b1;
      t_pin(1, 10, 1'b0, 0);
      t_pin(1, 10, 1'b1, 1);
      t_soft();
      t_qend();
      t_fault();
      t_hold();
      results();
   end

   initial begin
      #(25ns * 20000);
      n_fail++;
      results();
   end
endmodule : rsq_sequencer_tb
`default_nettype wire
